//--- core/eer_defines.svh
// Purpose: constants of the two-wire serial memory slave
// Assumes: included by its bare name from the timer and top design files
// Notes:   identity value below is arbitrary
`ifndef EER_DEFINES_SVH
`define EER_DEFINES_SVH

// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define EER_ADDR_W        11
`define EER_MEM_DEPTH     2048
`define EER_PG_W          4
`define EER_PG_DEPTH      16
`define EER_BANK_W        3

// ----------------------------------------------------------------
// slave address and bit positions
// ----------------------------------------------------------------
// arbitrary device type code, not taken from any part
`define EER_DEV_TYPE_DFLT 4'h5
`define EER_LAST_BIT      4'h7
`define EER_ACK_BIT       4'h8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define EER_T_WR_MS       10
`define EER_CLK_KHZ       200000
`define EER_WR_CYCLES     (`EER_T_WR_MS * `EER_CLK_KHZ)
`define EER_WR_CNT_W      21

`endif

//--- core/eer_pkg.sv
// Purpose: shared types of the two-wire serial memory slave
// Assumes: nothing
// Notes:   constants live in eer_defines.svh
package eer_pkg;

  // sampled bus lines travel together
  typedef struct packed {
    logic scl;
    logic sda;
  } eer_pins_s;

  // first byte after a start
  typedef struct packed {
    logic [3:0] dev_type;
    logic [2:0] bank;
    logic       rd;
  } eer_devaddr_s;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_DEVADDR  = 3'h1,
    ST_WORDADDR = 3'h2,
    ST_WRDATA   = 3'h3,
    ST_RDDATA   = 3'h4
  } eer_state_e;

endpackage : eer_pkg

//--- core/eer_sync.sv
// Purpose: two-flop synchroniser for the bus pins
// Assumes: pins idle high
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module eer_sync (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // pins
  input  eer_pkg::eer_pins_s i_pins,
  output eer_pkg::eer_pins_s o_pins
);

  eer_pkg::eer_pins_s meta;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta   <= '1;
      o_pins <= '1;
    end else if (i_ce) begin
      meta   <= i_pins;
      o_pins <= meta;
    end
  end

endmodule : eer_sync

//--- core/eer_wtimer.sv
// Purpose: self-timed programming cycle counter
// Assumes: i_start is a one-cycle pulse
// Notes:   a start while busy is ignored
`timescale 1ns/1ps
`include "eer_defines.svh"
module eer_wtimer #(
  parameter logic [`EER_WR_CNT_W-1:0] P_CYCLES = `EER_WR_CNT_W'(1000)
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  // control
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);

  logic [`EER_WR_CNT_W-1:0] cnt;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt    <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (!o_busy) begin
        if (i_start) begin
          cnt    <= P_CYCLES;
          o_busy <= 1'b1;
        end
      end else if (cnt[`EER_WR_CNT_W-1:1] == '0) begin
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end else begin
        cnt <= cnt - 1'b1;
      end
    end
  end

endmodule : eer_wtimer

//--- core/eer_top.sv
// Purpose: two-wire slave of a 2048-byte serial memory: reads, ack poll
// Assumes: pins oversampled on i_mclk; bus lines idle high
// Notes:   array is volatile storage standing in for the cells
//
// How it works
// R1: stop after written data starts programming
// R2: master polls with start plus write address
// R3: no acknowledge while programming runs
// R4: acknowledge poll once programming has finished
// R5: direction bit one selects a read
// R6: current, random and sequential reads supported
// R7: master's ninth read clock ends or continues
// R8: counter holds last accessed address plus one
// R9: acknowledge read address, then send byte
// R10: random read uses dummy write, repeated start
// R11: after repeated start send addressed byte
// R12: master ends read by no-ack, stop
// R13: master acknowledge keeps a read going
// R14: one further byte per master acknowledge
// R15: read counter increments across full width
// R16: highest location wraps to location zero
// R17: start and stop framed while clock high
// R18: address holds type, bank, direction
// R19: missing master acknowledge stops transmission
// R20: bus ignored during programming cycle
// R21: dummy write word address loads counter
`timescale 1ns/1ps
`include "eer_defines.svh"
module eer_top #(
  parameter int unsigned P_WR_CYCLES = `EER_WR_CYCLES,
  parameter logic [3:0]  P_DEV_TYPE  = `EER_DEV_TYPE_DFLT
) (
  // system
  input  wire logic i_mclk,
  input  wire logic i_sys_rst,
  input  wire logic i_ce,
  // two-wire pins
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_out,
  output logic      o_sda_oe,
  // status
  output logic      o_busy
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [`EER_WR_CNT_W-1:0] WR_CYC =
    P_WR_CYCLES[`EER_WR_CNT_W-1:0];

  eer_pkg::eer_pins_s    pins_raw;
  eer_pkg::eer_pins_s    pins_s;
  eer_pkg::eer_pins_s    pins_d;
  eer_pkg::eer_state_e   state;
  eer_pkg::eer_state_e   next_state;
  eer_pkg::eer_devaddr_s dev_rx;

  logic [3:0]             bit_cnt;
  logic [7:0]             rx_sr;
  logic [7:0]             tx_sr;
  logic [7:0]             rd_byte;
  logic [`EER_BANK_W-1:0] bank;
  logic [`EER_ADDR_W-1:0] addr_cnt;
  logic [6:0]             pg_base;
  logic [`EER_PG_DEPTH-1:0] pg_vld;
  logic [7:0]             pg  [0:`EER_PG_DEPTH-1];
  logic [7:0]             mem [0:`EER_MEM_DEPTH-1];

  logic ack_now;
  logic is_rd;
  logic mst_ack;
  logic wr_pend;
  logic sda_oe;
  logic next_sda_oe;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic byte_done;
  logic ack_end;
  logic dev_ok;
  logic rd_load;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;

  // ----------------------------------------------------------------
  // pin sampling and bus conditions
  // ----------------------------------------------------------------
  assign pins_raw.scl = i_scl;
  assign pins_raw.sda = i_sda;

  eer_sync u_sync (
    .i_clk  (i_mclk),
    .i_rst  (i_sys_rst),
    .i_ce   (i_ce),
    .i_pins (pins_raw),
    .o_pins (pins_s)
  );

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pins_d <= '1;
    end else if (i_ce) begin
      pins_d <= pins_s;
    end
  end

  assign scl_rise = pins_s.scl & ~pins_d.scl;
  assign scl_fall = ~pins_s.scl & pins_d.scl;
  // data may only move while the clock is low, so any data edge seen
  // with the clock high on both samples is framing
  assign start = pins_s.scl & pins_d.scl & pins_d.sda & ~pins_s.sda; // R17
  assign stop  = pins_s.scl & pins_d.scl & ~pins_d.sda & pins_s.sda; // R17

  assign byte_done = scl_fall & (bit_cnt == `EER_LAST_BIT);
  assign ack_end   = scl_fall & (bit_cnt == `EER_ACK_BIT);

  assign dev_rx = eer_pkg::eer_devaddr_s'(rx_sr); // R18
  // own address is not recognised at all while programming runs
  assign dev_ok = (dev_rx.dev_type == P_DEV_TYPE) & ~tmr_busy; // R3 R20 R4

  // a read starts on an acknowledged read address or continues on a
  // master acknowledge
  assign rd_load = ack_end &
    (((state == eer_pkg::ST_DEVADDR) & ack_now & is_rd) | // R9 R11
     ((state == eer_pkg::ST_RDDATA) & mst_ack));          // R13 R14
  assign rd_byte = mem[addr_cnt];

  // ----------------------------------------------------------------
  // bit and byte framing
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bit_cnt <= 4'h0;
      rx_sr   <= 8'h00;
      mst_ack <= 1'b0;
    end else if (i_ce) begin
      if (start) begin
        bit_cnt <= 4'hF; // clock fall after a start is not a bit
      end else if (scl_fall) begin
        bit_cnt <= ack_end ? 4'h0 : bit_cnt + 4'h1;
      end
      if (scl_rise && bit_cnt < `EER_ACK_BIT) begin
        rx_sr <= {rx_sr[6:0], pins_s.sda};
      end
      if (scl_rise && bit_cnt == `EER_ACK_BIT
          && state == eer_pkg::ST_RDDATA) begin
        mst_ack <= ~pins_s.sda; // R7 R12
      end
    end
  end

  // ----------------------------------------------------------------
  // transfer state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (start) begin
      next_state = eer_pkg::ST_DEVADDR;
    end else if (stop) begin
      next_state = eer_pkg::ST_IDLE;
    end else if (ack_end) begin
      unique case (state)
        eer_pkg::ST_DEVADDR: begin
          if (!ack_now) begin
            next_state = eer_pkg::ST_IDLE; // R3 R20
          end else if (is_rd) begin
            next_state = eer_pkg::ST_RDDATA; // R5 R6
          end else begin
            next_state = eer_pkg::ST_WORDADDR; // R5
          end
        end
        eer_pkg::ST_WORDADDR,
        eer_pkg::ST_WRDATA: begin
          next_state = eer_pkg::ST_WRDATA;
        end
        eer_pkg::ST_RDDATA: begin
          next_state = mst_ack ? eer_pkg::ST_RDDATA
                               : eer_pkg::ST_IDLE; // R19
        end
        eer_pkg::ST_IDLE: begin
          next_state = eer_pkg::ST_IDLE;
        end
        default: begin
          next_state = eer_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state   <= eer_pkg::ST_IDLE; // R17
      ack_now <= 1'b0;
      is_rd   <= 1'b0;
      bank    <= '0;
    end else if (i_ce) begin
      state <= next_state;
      if (byte_done && state == eer_pkg::ST_DEVADDR) begin
        ack_now <= dev_ok;
        is_rd   <= dev_rx.rd; // R5
        bank    <= dev_rx.bank; // R18
      end
    end
  end

  // ----------------------------------------------------------------
  // data line drive
  // ----------------------------------------------------------------
  always_comb begin
    next_sda_oe = sda_oe;
    if (start || stop) begin
      next_sda_oe = 1'b0;
    end else if (rd_load) begin
      next_sda_oe = ~rd_byte[7]; // R9 R14
    end else if (ack_end) begin
      next_sda_oe = 1'b0;
    end else if (byte_done) begin
      unique case (state)
        eer_pkg::ST_DEVADDR: begin
          next_sda_oe = dev_ok; // R3 R4
        end
        eer_pkg::ST_WORDADDR,
        eer_pkg::ST_WRDATA: begin
          next_sda_oe = 1'b1;
        end
        eer_pkg::ST_RDDATA,
        eer_pkg::ST_IDLE: begin
          next_sda_oe = 1'b0;
        end
        default: begin
          next_sda_oe = 1'b0;
        end
      endcase
    end else if (scl_fall && state == eer_pkg::ST_RDDATA
                 && bit_cnt < `EER_LAST_BIT) begin
      next_sda_oe = ~tx_sr[6];
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sda_oe <= 1'b0;
      tx_sr  <= 8'h00;
    end else if (i_ce) begin
      sda_oe <= next_sda_oe;
      if (rd_load) begin
        tx_sr <= rd_byte; // R8 R11
      end else if (scl_fall && state == eer_pkg::ST_RDDATA
                   && bit_cnt < `EER_LAST_BIT) begin
        tx_sr <= {tx_sr[6:0], 1'b0};
      end
    end
  end

  // open drain: the line is only ever pulled low
  assign o_sda_out = 1'b0;
  assign o_sda_oe  = sda_oe;

  // ----------------------------------------------------------------
  // address counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_cnt <= '0;
    end else if (i_ce) begin
      if (byte_done && state == eer_pkg::ST_WORDADDR) begin
        addr_cnt <= {bank, rx_sr}; // R21 R10
      end else if (byte_done && state == eer_pkg::ST_WRDATA) begin
        // writes roll within the page
        addr_cnt[`EER_PG_W-1:0] <= addr_cnt[`EER_PG_W-1:0] + 1'b1; // R8
      end else if (rd_load) begin
        // full-width carry, 2047 rolls to 0
        addr_cnt <= addr_cnt + 1'b1; // R8 R15 R16
      end
    end
  end

  // ----------------------------------------------------------------
  // page buffer and programming cycle
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_ce && byte_done && state == eer_pkg::ST_WRDATA) begin
      pg[addr_cnt[`EER_PG_W-1:0]] <= rx_sr;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pg_vld  <= '0;
      pg_base <= 7'h00;
      wr_pend <= 1'b0;
    end else if (i_ce) begin
      if (byte_done && state == eer_pkg::ST_WORDADDR) begin
        pg_vld  <= '0;
        pg_base <= {bank, rx_sr[7:4]};
      end else if (byte_done && state == eer_pkg::ST_WRDATA) begin
        pg_vld[addr_cnt[`EER_PG_W-1:0]] <= 1'b1;
        wr_pend <= 1'b1;
      end else if (tmr_start) begin
        wr_pend <= 1'b0;
      end else if (tmr_done) begin
        pg_vld <= '0;
      end
    end
  end

  // a dummy write has no data, so its stop starts nothing
  assign tmr_start = stop & wr_pend; // R1

  eer_wtimer #(
    .P_CYCLES (WR_CYC)
  ) u_wtimer (
    .i_clk   (i_mclk),
    .i_rst   (i_sys_rst),
    .i_ce    (i_ce),
    .i_start (tmr_start),
    .o_busy  (tmr_busy),
    .o_done  (tmr_done)
  );

  assign o_busy = tmr_busy;

  // cells hold contents over reset, so the array has none
  always_ff @(posedge i_mclk) begin
    if (i_ce && tmr_done) begin
      for (int i = 0; i < `EER_PG_DEPTH; i++) begin
        if (pg_vld[i]) begin
          mem[{pg_base, i[`EER_PG_W-1:0]}] <= pg[i]; // R1
        end
      end
    end
  end

endmodule : eer_top

//--- testbench/eer_top_sva.sv
// Purpose: bus-side checks of the serial memory slave
// Assumes: i_ce held high; bus lines idle high
// Notes:   pin events are unsynchronised, hence slack in windows
`timescale 1ns/1ps
module eer_top_sva #(
  parameter int unsigned P_WR_CYCLES = 2000
) (
  // system
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // two-wire pins and status
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_busy
);
  logic [31:0] busy_len;
  logic [3:0]  stop_age;
  logic        sda_q;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst)
      busy_len <= 32'h0;
    else
      busy_len <= o_busy ? busy_len + 32'h1 : 32'h0;
  end

  // age of the last stop seen at the pins, saturating
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sda_q    <= 1'h1;
      stop_age <= 4'hF;
    end else begin
      sda_q <= i_sda;
      if (i_scl && i_sda && !sda_q)
        stop_age <= 4'h0;
      else if (stop_age != 4'hF)
        stop_age <= stop_age + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  sequence scl_low2;
    !$past(i_scl) && !$past(i_scl, 2);
  endsequence
  sequence bus_cond;
    i_scl && $past(i_scl) && $changed(i_sda);
  endsequence

  AST_OD_LOW: assert property (o_sda_out == 1'b0)
    else $error("open drain value not low");
  AST_RISE_SCL_LOW: assert property ($rose(o_sda_oe) |-> scl_low2)
    else $error("data drive began with clock high");
  AST_FALL_SCL_LOW: assert property ($fell(o_sda_oe) |-> scl_low2)
    else $error("data drive ended with clock high");
  AST_BIT_HOLD: assert property ($rose(o_sda_oe) |-> o_sda_oe[*8])
    else $error("driven bit shorter than a bit time");
  AST_BUSY_QUIET: assert property (o_busy |-> !o_sda_oe)
    else $error("bus driven while programming");
  AST_BUSY_LEN: assert property ($fell(o_busy) |-> busy_len == P_WR_CYCLES)
    else $error("programming cycle length wrong");
  AST_BUSY_CAP: assert property (busy_len <= P_WR_CYCLES)
    else $error("programming cycle overran");
  AST_BUSY_AFTER_STOP: assert property ($rose(o_busy) |-> stop_age <= 4'h8)
    else $error("programming began without a stop");
  AST_COND_RELEASE: assert property (bus_cond |-> ##[1:6] !o_sda_oe)
    else $error("line held after start or stop");
endmodule : eer_top_sva

bind eer_top eer_top_sva #(.P_WR_CYCLES(P_WR_CYCLES)) eer_top_sva_inst (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_busy(o_busy));

//--- testbench/eer_tb_master.sv
// Purpose: two-wire bus master model driving the serial clock
// Assumes: i_lclk runs free; pull-up resolved outside
// Notes:   clock stands high between frames
`timescale 1ns/1ps
module eer_tb_master (
  // link clock
  input  wire logic i_lclk,
  // bus
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end

  // ----------------------------------------------------------------
  // bus primitives
  // ----------------------------------------------------------------
  // data changes only while the clock is low
  task automatic bit_io(input logic b, output logic got);
    @(posedge i_lclk);
    o_sda <= b;
    @(posedge i_lclk);
    o_scl <= 1'h1;
    repeat (2) @(posedge i_lclk);
    got = i_sda;
    o_scl <= 1'h0;
  endtask : bit_io

  task automatic start_c();
    @(posedge i_lclk);
    o_sda <= 1'h1;
    @(posedge i_lclk);
    o_scl <= 1'h1;
    repeat (2) @(posedge i_lclk);
    o_sda <= 1'h0;
    repeat (2) @(posedge i_lclk);
    o_scl <= 1'h0;
  endtask : start_c

  task automatic stop_c();
    @(posedge i_lclk);
    o_sda <= 1'h0;
    @(posedge i_lclk);
    o_scl <= 1'h1;
    repeat (2) @(posedge i_lclk);
    o_sda <= 1'h1;
    repeat (2) @(posedge i_lclk);
  endtask : stop_c

  task automatic tx(input logic [7:0] v, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(v[i], g);
    bit_io(1'h1, g);
    ack = (g === 1'h0);
  endtask : tx

  // ninth clock: low asks for more, high ends the read
  task automatic rx(input logic more, output logic [7:0] v);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(1'h1, v[i]);
    bit_io(!more, g);
  endtask : rx
endmodule : eer_tb_master

//--- testbench/tb.sv
// Purpose: self-checking bench of the serial memory slave
// Assumes: i_ce held high; short programming count
// Notes:   unwritten cells are never read back
`timescale 1ns/1ps
module tb;
  localparam int unsigned WR_CYC = 2000;
  // arbitrary device type code
  localparam logic [3:0]  DEV = 4'h5;
  logic       i_mclk;
  logic       i_sys_rst;
  logic       lclk;
  logic       scl;
  logic       m_sda;
  logic       sda;
  logic       sda_out;
  logic       sda_oe;
  logic       busy;
  logic       ack;
  logic [7:0] rd;
  int         mismatches;
  int         check_count;
  int         cycles;

  assign sda = m_sda & ~sda_oe;
  eer_top #(.P_WR_CYCLES(WR_CYC), .P_DEV_TYPE(DEV)) eer_top_inst (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(1'h1), .i_scl(scl),
    .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_busy(busy));
  eer_tb_master eer_tb_master_inst (
    .i_lclk(lclk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));

  always #2.5 i_mclk = ~i_mclk;
  always #15 lclk = ~lclk;

  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] g, input logic [7:0] e,
                       input string w);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask : check

  task automatic chk1(input logic g, input logic e, input string w);
    check({7'h0, g}, {7'h0, e}, w);
  endtask : chk1

  task automatic dev(input logic [2:0] bank, input logic rd_dir);
    eer_tb_master_inst.start_c();
    eer_tb_master_inst.tx({DEV, bank, rd_dir}, ack);
  endtask : dev

  // sends the first n bytes of d, most significant byte first
  task automatic write_seq(input logic [10:0] a, input logic [23:0] d,
                           input int n);
    dev(a[10:8], 1'h0);
    chk1(ack, 1'h1, "write address ack");
    eer_tb_master_inst.tx(a[7:0], ack);
    chk1(ack, 1'h1, "word ack");
    for (int i = 0; i < n; i++) begin
      eer_tb_master_inst.tx(d[23-8*i -: 8], ack);
      chk1(ack, 1'h1, "data ack");
    end
    eer_tb_master_inst.stop_c();
    chk1(busy, 1'h1, "busy after stop");
  endtask : write_seq

  // leaves the bus selected after the ack so a transfer can follow
  task automatic poll(input logic [2:0] bank);
    int n;
    n = 0;
    dev(bank, 1'h0);
    while (!ack && n < 40) begin
      eer_tb_master_inst.stop_c();
      dev(bank, 1'h0);
      n++;
    end
    chk1(ack, 1'h1, "poll ack");
  endtask : poll

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_write_poll_read();
    write_seq(11'h123, 24'hA55A3C, 3);
    dev(3'h1, 1'h0);
    chk1(ack, 1'h0, "ack while programming");
    eer_tb_master_inst.stop_c();
    poll(3'h1);
    eer_tb_master_inst.tx(8'h23, ack);
    chk1(ack, 1'h1, "dummy word ack");
    dev(3'h1, 1'h1);
    chk1(ack, 1'h1, "read address ack");
    eer_tb_master_inst.rx(1'h1, rd);
    check(rd, 8'hA5, "random read byte");
    eer_tb_master_inst.rx(1'h0, rd);
    check(rd, 8'h5A, "next read byte");
    @(posedge lclk);
    chk1(sda_oe, 1'h0, "driven after no ack");
    eer_tb_master_inst.stop_c();
  endtask : t_write_poll_read

  task automatic t_current_read();
    dev(3'h6, 1'h1);
    chk1(ack, 1'h1, "current read ack");
    eer_tb_master_inst.rx(1'h0, rd);
    check(rd, 8'h3C, "current address byte");
    eer_tb_master_inst.stop_c();
  endtask : t_current_read

  task automatic t_other_type();
    eer_tb_master_inst.start_c();
    eer_tb_master_inst.tx(8'h31, ack);
    chk1(ack, 1'h0, "foreign type answered");
    eer_tb_master_inst.stop_c();
  endtask : t_other_type

  task automatic t_wrap();
    write_seq(11'h000, 24'h960000, 1);
    poll(3'h0);
    eer_tb_master_inst.stop_c();
    write_seq(11'h7FF, 24'hC30000, 1);
    poll(3'h7);
    eer_tb_master_inst.tx(8'hFF, ack);
    chk1(ack, 1'h1, "top word ack");
    dev(3'h7, 1'h1);
    chk1(ack, 1'h1, "wrap read ack");
    eer_tb_master_inst.rx(1'h1, rd);
    check(rd, 8'hC3, "top byte");
    eer_tb_master_inst.rx(1'h0, rd);
    check(rd, 8'h96, "wrapped byte");
    eer_tb_master_inst.stop_c();
  endtask : t_wrap

  initial begin
    i_mclk = 1'h0;
    lclk = 1'h0;
    i_sys_rst = 1'h1;
    mismatches = 0;
    check_count = 0;
    cycles = 0;
    repeat (3) @(posedge i_mclk);
    i_sys_rst <= 1'h0;
    repeat (3) @(posedge i_mclk);
    t_write_poll_read();
    t_current_read();
    t_other_type();
    t_wrap();
    complete_run();
  end
endmodule : tb
